// [rtl/scd_pkg.sv]
package scd_pkg;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] SCD_ADDR_RATIO  = 8'h08;
   localparam logic [7:0] SCD_ADDR_SOURCE = 8'h09;
   localparam logic [7:0] SCD_ADDR_SYNC   = 8'h3A;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int         SCD_RATIO_LSB   = 0;
   localparam int         SCD_SRC_RF_BIT  = 0;
   localparam int         SCD_SRC_DCS_BIT = 1;
   localparam int         SCD_SYNC_EN_BIT = 1;
   localparam int         SCD_SYNC_ONE_BIT = 2;
   localparam int         SCD_SYNC_ARM_BIT = 3;
   localparam int         SCD_SYNC_LCK_BIT = 4;
   localparam logic [2:0] SCD_RATIO_RESET = 3'h0;
   localparam logic       SCD_RF_RESET    = 1'b0;
   localparam logic       SCD_DCS_RESET   = 1'b1;
   localparam logic [7:0] SCD_BYTE_ZERO   = 8'h00;

   // -----------------------------------------------------------------
   // Divider and stabilizer constants
   // -----------------------------------------------------------------
   localparam logic [1:0] SCD_PRESCALE_HALF = 2'h1;
   localparam int         SCD_PRESCALE_DIV  = 4;
   localparam int         SCD_CLK_MHZ       = 100;
   localparam int         SCD_DCS_MIN_MHZ   = 40;
   localparam int         SCD_DCS_MAX_PERIOD = SCD_CLK_MHZ / SCD_DCS_MIN_MHZ;
   localparam logic [7:0] SCD_PERIOD_MAX    = 8'hFF;
   localparam logic [7:0] SCD_PERIOD_ONE    = 8'h01;

   typedef enum logic [2:0] {
      SCD_SYNC_OFF   = 3'b001,
      SCD_SYNC_EVERY = 3'b010,
      SCD_SYNC_ONCE  = 3'b100
   } scd_sync_mode_t;

endpackage

// [rtl/scd_prescaler.sv]
`timescale 1ns/10ps
`default_nettype none

module scd_prescaler
   import scd_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic rfClkIn,
   output logic      preClk
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       prevIn;
      logic [1:0] edgeCnt;
      logic       level;
   } scd_pre_state_t;

   scd_pre_state_t st;
   scd_pre_state_t next_st;

   // Toggling every second rising edge gives a divide by four.
   always_comb begin
      next_st = st;
      next_st.prevIn = rfClkIn;
      if (rfClkIn && !st.prevIn) begin
         if (st.edgeCnt == SCD_PRESCALE_HALF) begin
            next_st.edgeCnt = '0;
            next_st.level   = ~st.level;
         end else begin
            next_st.edgeCnt = st.edgeCnt + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign preClk = st.level;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_prescale_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      (rfClkIn && !st.prevIn && st.edgeCnt == SCD_PRESCALE_HALF) |=> (preClk != $past(preClk)))
      else $error("Prescaler did not toggle on every second input edge.");

   chk_prescale_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(rfClkIn && !st.prevIn && st.edgeCnt == SCD_PRESCALE_HALF) |=> $stable(preClk))
      else $error("Prescaler output changed without a counted edge.");

endmodule

`default_nettype wire

// [rtl/scd_clock_front.sv]
`timescale 1ns/10ps
`default_nettype none

module scd_clock_front
   import scd_pkg::*;
#(
   parameter int DCS_MAX_PERIOD = SCD_DCS_MAX_PERIOD
)
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       nyqClkIn,
   input  wire logic       rfClkIn,
   input  wire logic       sysrefIn,
   input  wire logic       regWrEn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   output logic [7:0]      regRdData,
   output logic            sampleClk,
   output logic            sampleStrobe,
   output logic            dcsLocked
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0]     regRatio;
      logic           rfSelect;
      logic           dcsEnable;
      scd_sync_mode_t syncMode;
      logic           syncArmed;
      logic [2:0]     activeRatio;
      logic [2:0]     divCnt;
      logic           prevSrc;
      logic           prevSysref;
      logic [7:0]     periodCnt;
      logic [7:0]     lastPeriod;
      logic           locked;
      logic           dcsHigh;
      logic           clkOut;
      logic           strobe;
      logic [7:0]     rdData;
   } scd_front_state_t;

   scd_front_state_t st;
   scd_front_state_t next_st;

   logic preClk;
   logic srcLevel;
   logic srcRise;
   logic sysRise;
   logic syncAccept;
   logic divRise;
   logic dcsActive;
   logic rawLevel;
   logic [7:0] periodNow;

   scd_prescaler u_prescaler (
      .clk     (clk),
      .rst_n   (rst_n),
      .rfClkIn (rfClkIn),
      .preClk  (preClk)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic scd_sync_mode_t decode_sync(input logic [7:0] val);
      if (!val[SCD_SYNC_EN_BIT]) begin
         return SCD_SYNC_OFF;
      end else if (val[SCD_SYNC_ONE_BIT]) begin
         return SCD_SYNC_ONCE;
      end else begin
         return SCD_SYNC_EVERY;
      end
   endfunction

   function automatic logic [7:0] read_reg(input logic [7:0] addr, input scd_front_state_t s);
      logic [7:0] val;
      val = SCD_BYTE_ZERO;
      case (addr)
         SCD_ADDR_RATIO: begin
            val[SCD_RATIO_LSB +: 3] = s.regRatio;
         end
         SCD_ADDR_SOURCE: begin
            val[SCD_SRC_RF_BIT]  = s.rfSelect;
            val[SCD_SRC_DCS_BIT] = s.dcsEnable;
         end
         SCD_ADDR_SYNC: begin
            val[SCD_SYNC_EN_BIT]  = (s.syncMode != SCD_SYNC_OFF);
            val[SCD_SYNC_ONE_BIT] = (s.syncMode == SCD_SYNC_ONCE);
            val[SCD_SYNC_ARM_BIT] = s.syncArmed;
            val[SCD_SYNC_LCK_BIT] = s.locked;
         end
         default: begin
            val = SCD_BYTE_ZERO;
         end
      endcase
      return val;
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st    = st;
      srcLevel   = st.rfSelect ? preClk : nyqClkIn;
      srcRise    = srcLevel && !st.prevSrc;
      sysRise    = sysrefIn && !st.prevSysref;
      syncAccept = 1'b0;
      divRise    = 1'b0;
      periodNow  = (st.periodCnt == SCD_PERIOD_MAX) ? SCD_PERIOD_MAX : st.periodCnt + SCD_PERIOD_ONE;
      next_st.prevSrc    = srcLevel;
      next_st.prevSysref = sysrefIn;

      case (st.syncMode)
         SCD_SYNC_EVERY: syncAccept = sysRise;
         SCD_SYNC_ONCE:  syncAccept = sysRise && st.syncArmed;
         SCD_SYNC_OFF:   syncAccept = 1'b0;
         default:        syncAccept = 1'b0;
      endcase

      if (syncAccept) begin
         // The divider starts over so that every part sharing SYSREF aligns phase.
         next_st.divCnt      = '0;
         next_st.activeRatio = st.regRatio;
         next_st.syncArmed   = 1'b0;
         divRise             = srcRise;
      end else if (srcRise) begin
         if (st.divCnt == st.activeRatio) begin
            next_st.divCnt      = '0;
            next_st.activeRatio = st.regRatio;
            divRise             = 1'b1;
         end else begin
            next_st.divCnt = st.divCnt + 3'h1;
         end
      end

      // Period measurement feeds the lock detector.
      next_st.periodCnt = periodNow;
      if (divRise) begin
         next_st.periodCnt  = '0;
         next_st.lastPeriod = periodNow;
         next_st.locked     = (periodNow == st.lastPeriod) && (int'(periodNow) <= DCS_MAX_PERIOD);
      end else if (int'(periodNow) > DCS_MAX_PERIOD) begin
         next_st.locked = 1'b0;
      end

      dcsActive = st.dcsEnable || (next_st.activeRatio != SCD_RATIO_RESET);
      // Widened by one bit so that the half-period bound does not wrap for the two largest ratios.
      rawLevel  = (next_st.activeRatio == SCD_RATIO_RESET) ? srcLevel
                : ({1'b0, next_st.divCnt} < (({1'b0, next_st.activeRatio} + 4'h2) >> 1));

      // The falling edge is regenerated at half the measured period.
      if (divRise) begin
         next_st.dcsHigh = 1'b1;
      end else if (next_st.periodCnt >= (st.lastPeriod >> 1)) begin
         next_st.dcsHigh = 1'b0;
      end

      // Only the falling edge comes from the loop, so an unlocked loop is simply skipped.
      next_st.clkOut = (dcsActive && next_st.locked) ? (next_st.dcsHigh || divRise) : rawLevel;
      next_st.strobe = divRise;

      if (regWrEn) begin
         case (regAddr)
            SCD_ADDR_RATIO: begin
               next_st.regRatio = regWrData[SCD_RATIO_LSB +: 3];
            end
            SCD_ADDR_SOURCE: begin
               next_st.rfSelect  = regWrData[SCD_SRC_RF_BIT];
               next_st.dcsEnable = regWrData[SCD_SRC_DCS_BIT];
            end
            SCD_ADDR_SYNC: begin
               next_st.syncMode  = decode_sync(regWrData);
               next_st.syncArmed = 1'b1;
            end
            default: begin
               next_st.regRatio = st.regRatio;
            end
         endcase
      end
      next_st.rdData = read_reg(regAddr, st);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st             <= '0;
         st.regRatio    <= SCD_RATIO_RESET;
         st.activeRatio <= SCD_RATIO_RESET;
         st.rfSelect    <= SCD_RF_RESET;
         st.dcsEnable   <= SCD_DCS_RESET;
         st.syncMode    <= SCD_SYNC_OFF;
      end else begin
         st <= next_st;
      end
   end

   assign regRdData    = st.rdData;
   assign sampleClk    = st.clkOut;
   assign sampleStrobe = st.strobe;
   assign dcsLocked    = st.locked;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_reset_nyquist: assert property (@(posedge clk)
      !rst_n |=> (!st.rfSelect && st.activeRatio == SCD_RATIO_RESET))
      else $error("Source or ratio not at default after reset.");

   chk_divide_count: assert property (@(posedge clk) disable iff (!rst_n)
      (srcRise && !syncAccept && st.divCnt == st.activeRatio) |=> (st.strobe && st.divCnt == '0))
      else $error("Divider did not wrap at the programmed ratio.");

   chk_ratio_boundary: assert property (@(posedge clk) disable iff (!rst_n)
      (!divRise && !syncAccept) |=> $stable(st.activeRatio))
      else $error("Divide ratio changed away from a divider boundary.");

   chk_sync_restart: assert property (@(posedge clk) disable iff (!rst_n)
      syncAccept |=> (st.divCnt == '0))
      else $error("Accepted SYSREF did not restart the divider.");

   chk_sync_once: assert property (@(posedge clk) disable iff (!rst_n)
      (syncAccept && !regWrEn) |=> !st.syncArmed)
      else $error("Single-shot resync stayed armed after a SYSREF.");

   chk_sync_off: assert property (@(posedge clk) disable iff (!rst_n)
      (st.syncMode == SCD_SYNC_OFF) |-> !syncAccept)
      else $error("SYSREF accepted while resync is off.");

   chk_dcs_forced: assert property (@(posedge clk) disable iff (!rst_n)
      (next_st.activeRatio != SCD_RATIO_RESET && next_st.locked) |=> (st.clkOut == $past(next_st.dcsHigh || divRise)))
      else $error("Stabilizer not forced on for a ratio above one.");

   chk_bypass_raw: assert property (@(posedge clk) disable iff (!rst_n)
      (!next_st.locked) |=> (st.clkOut == $past(rawLevel)))
      else $error("Output did not follow the raw clock while unlocked.");

   chk_slow_unlock: assert property (@(posedge clk) disable iff (!rst_n)
      (int'(periodNow) > DCS_MAX_PERIOD) |=> !st.locked)
      else $error("Stabilizer reported lock at a slow clock rate.");

   chk_strobe_rise: assert property (@(posedge clk) disable iff (!rst_n)
      sampleStrobe && dcsActive && dcsLocked |-> sampleClk)
      else $error("Sample strobe without a rising sample clock.");

endmodule

`default_nettype wire

// [verification/scd_clock_source.sv]
`timescale 1ns/10ps
`default_nettype none

// Free-running sources; all levels move on the falling edge only.
module scd_clock_source (
   input  wire logic       clk,
   input  wire logic [7:0] nyqHigh,
   input  wire logic [7:0] nyqLow,
   input  wire logic [7:0] rfHigh,
   input  wire logic [7:0] rfLow,
   output logic            nyqClkIn,
   output logic            rfClkIn,
   output logic            sysrefIn
);
   int nyqCnt = 0;
   int rfCnt  = 0;

   initial begin
      nyqClkIn = 1'b0;
      rfClkIn  = 1'b0;
      sysrefIn = 1'b0;
   end

   // Low time is never below one cycle, so every rise stays visible.
   always @(negedge clk) begin
      nyqCnt = (nyqCnt + 1 >= nyqHigh + nyqLow) ? 0 : nyqCnt + 1;
      rfCnt  = (rfCnt + 1 >= rfHigh + rfLow) ? 0 : rfCnt + 1;
      nyqClkIn <= (nyqCnt < int'(nyqHigh));
      rfClkIn  <= (rfCnt < int'(rfHigh));
   end

   task automatic pulseSysref();
      @(negedge clk);
      sysrefIn <= 1'b1;
      repeat (2) @(negedge clk);
      sysrefIn <= 1'b0;
   endtask
endmodule

`default_nettype wire

// [verification/tb_sample_clock_select_divider.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_sample_clock_select_divider
   import scd_pkg::*;
;
   logic       clk;
   logic       rst_n;
   logic       regWrEn;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic [7:0] regRdData;
   logic       sampleClk;
   logic       sampleStrobe;
   logic       dcsLocked;
   logic       nyqClkIn;
   logic       rfClkIn;
   logic       sysrefIn;
   logic [7:0] nyqHigh;
   logic [7:0] nyqLow;
   logic [7:0] rfHigh;
   logic [7:0] rfLow;
   logic [7:0] rd;
   int         bad_count   = 0;
   int         check_count = 0;
   int         cycles      = 0;
   int         n;
   int         a;
   int         b;

   // A long lock window lets the stabilizer lock at these slow test rates.
   scd_clock_front #(.DCS_MAX_PERIOD(16)) uut (.clk(clk), .rst_n(rst_n), .nyqClkIn(nyqClkIn),
      .rfClkIn(rfClkIn), .sysrefIn(sysrefIn), .regWrEn(regWrEn), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData), .sampleClk(sampleClk),
      .sampleStrobe(sampleStrobe), .dcsLocked(dcsLocked));
   scd_clock_source src (.clk(clk), .nyqHigh(nyqHigh), .nyqLow(nyqLow), .rfHigh(rfHigh),
      .rfLow(rfLow), .nyqClkIn(nyqClkIn), .rfClkIn(rfClkIn), .sysrefIn(sysrefIn));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic regWrite(input logic [7:0] ad, input logic [7:0] d);
      @(negedge clk);
      regAddr   = ad;
      regWrData = d;
      regWrEn   = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
   endtask

   task automatic regRead(input logic [7:0] ad, output logic [7:0] d);
      @(negedge clk);
      regAddr = ad;
      @(negedge clk);
      d = regRdData;
   endtask

   // Counts falling edges up to the next strobe; bounded so a dead divider ends.
   task automatic waitStrobe(output int c);
      c = 0;
      @(negedge clk);
      while (sampleStrobe !== 1'b1 && c < 2000) begin
         @(negedge clk);
         c++;
      end
      c++;
   endtask

   task automatic highTime(output int h);
      int w;
      waitStrobe(w);
      h = 0;
      w = 0;
      while (sampleClk !== 1'b1 && w < 3) begin
         @(negedge clk);
         w++;
      end
      while (sampleClk === 1'b1 && h < 100) begin
         @(negedge clk);
         h++;
      end
   endtask

   task automatic syncDelay(input int k, output int d);
      waitStrobe(d);
      repeat (4 * k) @(negedge clk);
      src.pulseSysref();
      waitStrobe(d);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end
      else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      rst_n     = 1'b0;
      regWrEn   = 1'b0;
      regAddr   = 8'h00;
      regWrData = 8'h00;
      nyqHigh   = 8'h02;
      nyqLow    = 8'h02;
      rfHigh    = 8'h01;
      rfLow     = 8'h01;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      regRead(SCD_ADDR_RATIO, rd);
      check(rd, 8'h00);
      regRead(SCD_ADDR_SOURCE, rd);
      check(rd, 8'h02);
      regRead(SCD_ADDR_SYNC, rd);
      check(rd, 8'h00);
      regWrite(8'h10, 8'hff);
      regRead(8'h10, rd);
      check(rd, 8'h00);
      $display("test registers done");
      for (int r = 1; r <= 8; r++) begin
         regWrite(SCD_ADDR_RATIO, 8'(r - 1));
         regRead(SCD_ADDR_RATIO, rd);
         check(rd, 8'(r - 1));
         repeat (3) waitStrobe(n);
         check(8'(n), 8'(4 * r));
      end
      highTime(n);
      check(8'(n), 8'h10);
      $display("test ratios done");
      nyqHigh = 8'h03;
      nyqLow  = 8'h03;
      regWrite(SCD_ADDR_RATIO, 8'h01);
      regWrite(SCD_ADDR_SOURCE, 8'h03);
      repeat (3) waitStrobe(n);
      check(8'(n), 8'h10);
      regWrite(SCD_ADDR_SOURCE, 8'h02);
      repeat (3) waitStrobe(n);
      check(8'(n), 8'h0c);
      $display("test sources done");
      nyqHigh = 8'h01;
      nyqLow  = 8'h03;
      regWrite(SCD_ADDR_RATIO, 8'h00);
      regWrite(SCD_ADDR_SOURCE, 8'h00);
      highTime(n);
      check(8'(n), 8'h01);
      regWrite(SCD_ADDR_SOURCE, 8'h02);
      repeat (4) waitStrobe(n);
      highTime(n);
      check({7'h00, dcsLocked}, 8'h01);
      check(8'(n), 8'h02);
      regWrite(SCD_ADDR_SOURCE, 8'h00);
      regWrite(SCD_ADDR_RATIO, 8'h02);
      repeat (4) waitStrobe(n);
      highTime(n);
      check(8'(n), 8'h06);
      regWrite(SCD_ADDR_RATIO, 8'h00);
      regWrite(SCD_ADDR_SOURCE, 8'h02);
      nyqHigh = 8'h02;
      nyqLow  = 8'h12;
      repeat (4) waitStrobe(n);
      highTime(n);
      check({7'h00, dcsLocked}, 8'h00);
      check(8'(n), 8'h02);
      $display("test stabilizer done");
      nyqHigh = 8'h02;
      nyqLow  = 8'h02;
      regWrite(SCD_ADDR_RATIO, 8'h03);
      repeat (3) waitStrobe(n);
      syncDelay(1, a);
      syncDelay(2, b);
      check(8'(a - b), 8'h04);
      regWrite(SCD_ADDR_SYNC, 8'h02);
      syncDelay(1, a);
      syncDelay(2, b);
      check(8'(b), 8'(a));
      regWrite(SCD_ADDR_SYNC, 8'h06);
      regRead(SCD_ADDR_SYNC, rd);
      check(rd & 8'h0e, 8'h0e);
      syncDelay(1, b);
      check(8'(b), 8'(a));
      regRead(SCD_ADDR_SYNC, rd);
      check(rd & 8'h08, 8'h00);
      syncDelay(2, b);
      check(8'(a - b), 8'h08);
      regWrite(SCD_ADDR_SYNC, 8'h06);
      syncDelay(2, b);
      check(8'(b), 8'(a));
      $display("test resync done");
      summarize();
   end
endmodule

`default_nettype wire
